//--- hw/bor_ctl_pkg.sv
// Purpose: Shared constants and types for the brown-out response slice.
// Assumes: 32-bit AHB-Lite register access, word-aligned registers.
// Notes:   Every offset, field position, reset value and count lives here.
package bor_ctl_pkg;

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [11:0] OFFSET_PERIPHERAL_PINS = 12'h018;
  localparam logic [11:0] OFFSET_GPIO_PORTS      = 12'h01C;
  localparam logic [11:0] OFFSET_BOR_CONTROL     = 12'h030;
  localparam logic [11:0] OFFSET_BOR_STATUS      = 12'h060;

  // ****************************************
  // Capability values
  // ****************************************
  localparam logic [31:0] PERIPHERAL_PINS_VALUE = 32'h3F00_7FFF;
  localparam logic [31:0] GPIO_PORTS_VALUE      = 32'h0000_001F;

  // ****************************************
  // Brown-out control field layout
  // ****************************************
  localparam int          WAIT_COUNT_LSB     = 2;
  localparam int          WAIT_COUNT_WIDTH   = 14;
  localparam int          RESET_SELECT_BIT   = 1;
  localparam int          FILTER_ENABLE_BIT  = 0;
  localparam logic [13:0] WAIT_COUNT_RESET   = 14'h1FFF;
  localparam logic        RESET_SELECT_RESET = 1'b0;
  localparam logic        FILTER_ENABLE_RESET = 1'b1;
  localparam int          WAIT_COUNT_MINIMUM = 10000;
  localparam logic [31:0] BOR_CONTROL_MASK   = 32'h0000_FFFF;

  // ****************************************
  // Status register field layout
  // ****************************************
  localparam int   REPORT_ENABLE_BIT   = 0;
  localparam int   FILTER_BUSY_BIT     = 1;
  localparam int   NOISE_SEEN_BIT      = 2;
  localparam int   DETECTOR_LEVEL_BIT  = 3;
  localparam logic REPORT_ENABLE_RESET = 1'b1;

  // ****************************************
  // Bus encodings
  // ****************************************
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;

  // Filter sequencer states
  typedef enum logic {
    FILTER_IDLE,
    FILTER_WAIT
  } filter_state_t;

endpackage : bor_ctl_pkg

//--- hw/rise_detect.sv
// Purpose: One-cycle pulse on each rising level of a synchronous input.
// Assumes: Input is already synchronous to hclk.
// Notes:   Level output is the registered copy of the input.
`timescale 1ns/1ps

module rise_detect (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Level in, pulse out
  input  wire logic level_in,
  output logic      level_q,
  output logic      rise_pulse
);

  typedef struct packed {
    logic prev;
  } rise_state_t;

  rise_state_t state;
  rise_state_t next_state;

  // Track the previous level
  always_comb begin
    next_state      = state;
    next_state.prev = level_in;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level_q    = state.prev;
  assign rise_pulse = level_in & ~state.prev;

endmodule : rise_detect

//--- hw/wait_counter.sv
// Purpose: Counts oscillator ticks up to a limit latched at load.
// Assumes: Ticks are one-cycle pulses in the hclk domain.
// Notes:   A limit of zero raises expired two cycles after load.
`timescale 1ns/1ps

module wait_counter (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Control
  input  wire logic        load,
  input  wire logic [13:0] limit,
  input  wire logic        tick,
  // Result
  output logic             running,
  output logic             expired
);

  typedef struct packed {
    logic        running;
    logic        expired;
    logic [13:0] limit;
    logic [13:0] count;
  } count_state_t;

  count_state_t state;
  count_state_t next_state;

  // Load, count ticks, flag expiry once
  always_comb begin
    next_state         = state;
    next_state.expired = 1'b0;
    if (load) begin
      next_state.running = 1'b1;
      next_state.count   = '0;
      next_state.limit   = limit;
    end else if (state.running) begin
      if (state.count == state.limit) begin
        next_state.expired = 1'b1;
        next_state.running = 1'b0;
      end else if (tick) begin
        next_state.count = state.count + 14'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign running = state.running;
  assign expired = state.expired;

endmodule : wait_counter

//--- hw/bor_response_ctl.sv
// Purpose: Capability registers and brown-out response controller.
// Assumes: AHB-Lite slave, zero wait states, word registers.
// Notes:   Detector and oscillator inputs are synchronous to hclk.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module bor_response_ctl (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Analog and oscillator inputs
  input  wire logic        brownout_detector,
  input  wire logic        internal_oscillator,
  // Event outputs
  output logic             brownout_reset_request,
  output logic             brownout_interrupt_request
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [13:0]                brownout_wait_count;
    logic                       brownout_reset_select;
    logic                       brownout_filter_enable;
    logic                       report_enable;
    logic                       noise_seen;
    logic                       wr_pending;
    logic [11:0]                wr_addr;
    logic [3:0]                 wr_lanes;
    logic [31:0]                rdata;
    bor_ctl_pkg::filter_state_t fsm;
    logic                       reset_req;
    logic                       irq_req;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;

  // ****************************************
  // Helper signals
  // ****************************************
  logic        addr_phase;
  logic [3:0]  addr_lanes;
  logic [31:0] lane_mask;
  logic [31:0] control_image;
  logic [31:0] status_image;
  logic [31:0] control_merged;
  logic [31:0] status_merged;
  logic [31:0] read_value;
  logic        detector_level;
  logic        detector_rise;
  logic        osc_tick;
  logic        wait_load;
  logic        wait_running;
  logic        wait_expired;
  logic        report_now;
  logic        wr_control;
  logic        wr_status;

  // ****************************************
  // Sub-blocks
  // ****************************************

  // Rising edges of the detector output
  rise_detect u_detector_edge (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .level_in   (brownout_detector),
    .level_q    (detector_level),
    .rise_pulse (detector_rise)
  );

  // One tick per oscillator period
  rise_detect u_osc_edge (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .level_in   (internal_oscillator),
    .level_q    (),
    .rise_pulse (osc_tick)
  );

  // Filter wait in oscillator periods
  wait_counter u_wait (
    .hclk    (hclk),
    .hresetn (hresetn),
    .load    (wait_load),
    .limit   (state.brownout_wait_count),
    .tick    (osc_tick),
    .running (wait_running),
    .expired (wait_expired)
  );

  // ****************************************
  // Bus decode
  // ****************************************

  // Valid address phase seen by this slave
  assign addr_phase = hsel & htrans[1] & hready;

  // Byte lanes from size and low address bits
  always_comb begin
    addr_lanes = 4'hF;
    if (hsize == bor_ctl_pkg::HSIZE_BYTE) begin
      addr_lanes = 4'h1 << haddr[1:0];
    end else if (hsize == bor_ctl_pkg::HSIZE_HALF) begin
      addr_lanes = haddr[1] ? 4'hC : 4'h3;
    end
  end

  // Expand captured lanes to a bit mask
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_lane
      assign lane_mask[lane*8 +: 8] = {8{state.wr_lanes[lane]}};
    end
  endgenerate

  // ****************************************
  // Register images
  // ****************************************

  // Control register as software sees it; bits 31..16 read zero
  always_comb begin
    control_image = '0;
    control_image[bor_ctl_pkg::WAIT_COUNT_LSB +: bor_ctl_pkg::WAIT_COUNT_WIDTH] =
      state.brownout_wait_count;
    control_image[bor_ctl_pkg::RESET_SELECT_BIT]  = state.brownout_reset_select;
    control_image[bor_ctl_pkg::FILTER_ENABLE_BIT] = state.brownout_filter_enable;
  end

  // Status register shows the sequencer and detector state
  always_comb begin
    status_image = '0;
    status_image[bor_ctl_pkg::REPORT_ENABLE_BIT]  = state.report_enable;
    status_image[bor_ctl_pkg::FILTER_BUSY_BIT]    = (state.fsm == bor_ctl_pkg::FILTER_WAIT);
    status_image[bor_ctl_pkg::NOISE_SEEN_BIT]     = state.noise_seen;
    status_image[bor_ctl_pkg::DETECTOR_LEVEL_BIT] = detector_level;
  end

  // Lane-merged write values
  assign control_merged = (control_image & ~lane_mask) | (hwdata & lane_mask);
  assign status_merged  = hwdata & lane_mask;

  // Read mux; reserved bits and unmapped addresses read zero
  always_comb begin
    case (haddr[11:0])
      bor_ctl_pkg::OFFSET_PERIPHERAL_PINS: read_value = bor_ctl_pkg::PERIPHERAL_PINS_VALUE;
      bor_ctl_pkg::OFFSET_GPIO_PORTS:      read_value = bor_ctl_pkg::GPIO_PORTS_VALUE;
      bor_ctl_pkg::OFFSET_BOR_CONTROL:     read_value = control_image & bor_ctl_pkg::BOR_CONTROL_MASK;
      bor_ctl_pkg::OFFSET_BOR_STATUS:      read_value = status_image;
      default:                             read_value = '0;
    endcase
  end

  // Data-phase write targets; capability offsets have none
  assign wr_control = state.wr_pending && (state.wr_addr == bor_ctl_pkg::OFFSET_BOR_CONTROL);
  assign wr_status  = state.wr_pending && (state.wr_addr == bor_ctl_pkg::OFFSET_BOR_STATUS);

  // ****************************************
  // Filter sequencer controls
  // ****************************************

  // Start a wait on a new assertion with filtering on
  assign wait_load = (state.fsm == bor_ctl_pkg::FILTER_IDLE) && detector_rise
                     && state.brownout_filter_enable;

  // Decide whether to raise an event this cycle
  always_comb begin
    report_now = 1'b0;
    case (state.fsm)
      bor_ctl_pkg::FILTER_IDLE: begin
        report_now = detector_rise && !state.brownout_filter_enable
                     && state.report_enable;
      end
      bor_ctl_pkg::FILTER_WAIT: begin
        report_now = wait_expired && detector_level && state.report_enable;
      end
      default: begin
        report_now = 1'b0;
      end
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_state           = state;
    next_state.reset_req = 1'b0;
    next_state.irq_req   = 1'b0;

    // Address phase: capture write target or prepare read data
    next_state.wr_pending = 1'b0;
    if (addr_phase) begin
      if (hwrite) begin
        next_state.wr_pending = 1'b1;
        next_state.wr_addr    = haddr[11:0];
        next_state.wr_lanes   = addr_lanes;
      end else begin
        next_state.rdata = read_value;
      end
    end

    // Data phase: update control fields
    if (wr_control) begin
      next_state.brownout_wait_count =
        control_merged[bor_ctl_pkg::WAIT_COUNT_LSB +: bor_ctl_pkg::WAIT_COUNT_WIDTH];
      next_state.brownout_reset_select  = control_merged[bor_ctl_pkg::RESET_SELECT_BIT];
      next_state.brownout_filter_enable = control_merged[bor_ctl_pkg::FILTER_ENABLE_BIT];
    end

    // Data phase: status enable and write-one-to-clear noise flag
    if (wr_status) begin
      if (state.wr_lanes[0]) begin
        next_state.report_enable = hwdata[bor_ctl_pkg::REPORT_ENABLE_BIT];
      end
      if (status_merged[bor_ctl_pkg::NOISE_SEEN_BIT]) begin
        next_state.noise_seen = 1'b0;
      end
    end

    // Filter sequencer; assertions during a wait are ignored
    case (state.fsm)
      bor_ctl_pkg::FILTER_IDLE: begin
        if (wait_load) begin
          next_state.fsm = bor_ctl_pkg::FILTER_WAIT;
        end
      end
      bor_ctl_pkg::FILTER_WAIT: begin
        if (wait_expired) begin
          next_state.fsm = bor_ctl_pkg::FILTER_IDLE;
          if (!detector_level) begin
            next_state.noise_seen = 1'b1;
          end
        end
      end
      default: begin
        next_state.fsm = bor_ctl_pkg::FILTER_IDLE;
      end
    endcase

    // Route the event to reset or interrupt
    if (report_now) begin
      next_state.reset_req = state.brownout_reset_select;
      next_state.irq_req   = !state.brownout_reset_select;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state                        <= '0;
      state.brownout_wait_count    <= bor_ctl_pkg::WAIT_COUNT_RESET;
      state.brownout_reset_select  <= bor_ctl_pkg::RESET_SELECT_RESET;
      state.brownout_filter_enable <= bor_ctl_pkg::FILTER_ENABLE_RESET;
      state.report_enable          <= bor_ctl_pkg::REPORT_ENABLE_RESET;
      state.fsm                    <= bor_ctl_pkg::FILTER_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = state.rdata;

  // Registered one-cycle event pulses
  assign brownout_reset_request     = state.reset_req;
  assign brownout_interrupt_request = state.irq_req;

endmodule : bor_response_ctl

//--- test/bor_partner.sv
// Purpose: Stand-in for the brown-out detector and the internal oscillator.
// Assumes: Bench drives the commands by non-blocking assignment at hclk rise.
// Notes:   A glitch holds the detector high for three cycles only.
`timescale 1ns/1ps

module bor_partner (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Bench commands
  input  wire logic osc_slow,
  input  wire logic hold,
  input  wire logic glitch,
  // Analog side
  output logic      brownout_detector,
  output logic      internal_oscillator
);
  logic [3:0] osc_cnt;
  logic [1:0] glitch_cnt;

  // ****************************************
  // Oscillator and noise stretcher
  // ****************************************
  // Period is 4 or 12 hclk cycles, always slower than hclk/2
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_cnt             <= 4'h0;
      internal_oscillator <= 1'b0;
      glitch_cnt          <= 2'h0;
    end else begin
      osc_cnt <= osc_cnt + 4'h1;
      if (osc_cnt >= (osc_slow ? 4'h5 : 4'h1)) begin
        osc_cnt             <= 4'h0;
        internal_oscillator <= !internal_oscillator;
      end
      if (glitch) begin
        glitch_cnt <= 2'h3;
      end else if (glitch_cnt != 2'h0) begin
        glitch_cnt <= glitch_cnt - 2'h1;
      end
    end
  end

  // Steady brown-out or short noise burst
  assign brownout_detector = hold | (glitch_cnt != 2'h0);
endmodule : bor_partner

//--- test/bor_monitor.sv
// Purpose: Port checker for the brown-out response slice.
// Assumes: Word transfers only; a shadow tracks control writes.
// Notes:   Bound to the design below.
`timescale 1ns/1ps

module bor_monitor (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  // Events
  input wire logic        brownout_detector,
  input wire logic        brownout_reset_request,
  input wire logic        brownout_interrupt_request
);
  logic        ap_valid;
  logic        ap_write;
  logic [11:0] ap_addr;
  logic [15:0] ctl;
  logic        rd_ok;
  logic        req;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ****************************************
  // Address phase capture and control shadow
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 12'h000;
      ctl      <= 16'h7FFD;
    end else begin
      ap_valid <= hsel & htrans[1] & hready;
      ap_write <= hwrite;
      ap_addr  <= haddr[11:0];
      if (ap_valid && ap_write && ap_addr == 12'h030) begin
        ctl <= hwdata[15:0];
      end
    end
  end

  // Read data phase and any request
  assign rd_ok = ap_valid && !ap_write;
  assign req   = brownout_reset_request | brownout_interrupt_request;

  // ****************************************
  // Properties
  // ****************************************
  property p_timer; rd_ok && ap_addr == 12'h018 |-> hrdata[29:24] == 6'h3F; endproperty
  a_timer: assert property (p_timer) else $error("timer pin bits wrong");
  property p_cmp_pwm; rd_ok && ap_addr == 12'h018 |-> hrdata[14:0] == 15'h7FFF; endproperty
  a_cmp_pwm: assert property (p_cmp_pwm) else $error("pin bits wrong");
  property p_ports; rd_ok && ap_addr == 12'h01C |-> hrdata[4:0] == 5'h1F; endproperty
  a_ports: assert property (p_ports) else $error("port bits wrong");
  property p_ctl; rd_ok && ap_addr == 12'h030 |-> hrdata[15:0] == $past(ctl); endproperty
  a_ctl: assert property (p_ctl) else $error("control readback wrong");
  property p_excl; !(brownout_reset_request && brownout_interrupt_request); endproperty
  a_excl: assert property (p_excl) else $error("both requests high");
  property p_off_rst; $rose(brownout_detector) && !ctl[0] && ctl[1] |-> ##1 brownout_reset_request; endproperty
  a_off_rst: assert property (p_off_rst) else $error("reset request late");
  property p_off_int; $rose(brownout_detector) && !ctl[0] && !ctl[1] |-> ##1 brownout_interrupt_request; endproperty
  a_off_int: assert property (p_off_int) else $error("interrupt request late");
  property p_quiet; $rose(brownout_detector) && ctl[0] && ctl[15:2] != 14'h0000 |-> !req [*3]; endproperty
  a_quiet: assert property (p_quiet) else $error("request before wait");
  // Filtered events follow the resampled level, direct ones the rising level
  property p_resample; req |-> (ctl[0] ? $past(brownout_detector, 2) : $past(brownout_detector, 1)); endproperty
  a_resample: assert property (p_resample) else $error("request without detector");

  // Main scenarios
  c_rst: cover property (brownout_reset_request);
  c_int: cover property (brownout_interrupt_request);
  c_filt: cover property ($rose(brownout_detector) && ctl[0]);
endmodule : bor_monitor

bind bor_response_ctl bor_monitor mon_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .brownout_detector(brownout_detector), .brownout_reset_request(brownout_reset_request),
  .brownout_interrupt_request(brownout_interrupt_request)
);

//--- test/tb.sv
// Purpose: Self-checking bench for the brown-out response slice.
// Assumes: Word transfers; the partner drives detector and oscillator.
// Notes:   Register rows, event rows, then a reset in mid-wait.
`timescale 1ns/1ps

module tb;
  typedef struct packed {
    logic        wr;
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [11:0] raddr;
    logic [31:0] exp;
    logic [31:0] mask;
  } reg_row_t;
  typedef struct packed {
    logic [15:0] ctl;
    logic        slow;
    logic [1:0]  stim;
    logic [3:0]  n_rst;
    logic [3:0]  n_int;
  } ev_row_t;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        brownout_detector;
  logic        internal_oscillator;
  logic        rst_req;
  logic        int_req;
  logic        osc_slow;
  logic        hold;
  logic        glitch;
  logic [31:0] rd;
  logic [3:0]  n_rst;
  logic [3:0]  n_int;
  int          failures;
  int          checks;
  reg_row_t    regs [7];
  ev_row_t     evs [6];

  bor_response_ctl dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .brownout_detector(brownout_detector),
    .internal_oscillator(internal_oscillator), .brownout_reset_request(rst_req),
    .brownout_interrupt_request(int_req)
  );
  bor_partner partner_u (
    .hclk(hclk), .hresetn(hresetn), .osc_slow(osc_slow), .hold(hold), .glitch(glitch),
    .brownout_detector(brownout_detector), .internal_oscillator(internal_oscillator)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Bounded wait for hready high at a rising edge
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      failures++;
      test_done();
    end
  endtask : wait_ready

  // One word transfer, then an idle cycle so a read sees the last write
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] r);
    htrans <= 2'h2;
    haddr  <= {20'h0_0000, a};
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    r = hrdata;
    @(posedge hclk);
  endtask : bus

  // Count request pulses, sampled after each edge settles
  task automatic watch(input int cycles);
    n_rst = 4'h0;
    n_int = 4'h0;
    repeat (cycles) begin
      @(posedge hclk);
      #1;
      n_rst += {3'h0, rst_req};
      n_int += {3'h0, int_req};
    end
  endtask : watch

  // Clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = !hclk;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    hresetn  = 1'b0;
    hsel     = 1'b1;
    htrans   = 2'h0;
    haddr    = 32'h0000_0000;
    hwrite   = 1'b0;
    hsize    = 3'h2;
    hwdata   = 32'h0000_0000;
    osc_slow = 1'b0;
    hold     = 1'b0;
    glitch   = 1'b0;
    failures = 0;
    checks   = 0;
    regs[0] = '{1'b0, 12'h000, 32'h0000_0000, 12'h030, 32'h0000_7FFD, 32'h0000_FFFF};
    regs[1] = '{1'b0, 12'h000, 32'h0000_0000, 12'h018, 32'h3F00_7FFF, 32'h3F00_7FFF};
    regs[2] = '{1'b1, 12'h018, 32'h0000_0000, 12'h018, 32'h3F00_7FFF, 32'h3F00_7FFF};
    regs[3] = '{1'b1, 12'h01C, 32'h0000_0000, 12'h01C, 32'h0000_001F, 32'h0000_001F};
    regs[4] = '{1'b1, 12'h030, 32'h0000_FFFF, 12'h030, 32'h0000_FFFF, 32'h0000_FFFF};
    regs[5] = '{1'b1, 12'h0F0, 32'h0000_0000, 12'h030, 32'h0000_FFFF, 32'h0000_FFFF};
    regs[6] = '{1'b1, 12'h030, 32'h0000_0002, 12'h030, 32'h0000_0002, 32'h0000_FFFF};
    evs[0] = '{16'h0002, 1'b0, 2'h0, 4'h1, 4'h0};
    evs[1] = '{16'h0000, 1'b0, 2'h0, 4'h0, 4'h1};
    evs[2] = '{16'h000F, 1'b0, 2'h0, 4'h0, 4'h0};
    evs[3] = '{16'h000F, 1'b1, 2'h2, 4'h1, 4'h0};
    evs[4] = '{16'h000D, 1'b1, 2'h1, 4'h0, 4'h1};
    evs[5] = '{16'h0001, 1'b0, 2'h1, 4'h0, 4'h1};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // Register rows
    foreach (regs[i]) begin
      if (regs[i].wr) begin
        bus(1'b1, regs[i].waddr, regs[i].wdata, rd);
      end
      bus(1'b0, regs[i].raddr, 32'h0000_0000, rd);
      check("register read", rd & regs[i].mask, regs[i].exp);
      check("bus response", {31'h0000_0000, hresp}, 32'h0000_0000);
    end
    // Event rows: noise burst, steady level, or level with a dip mid-wait
    foreach (evs[i]) begin
      bus(1'b1, 12'h030, {16'h0000, evs[i].ctl}, rd);
      osc_slow <= evs[i].slow;
      glitch   <= (evs[i].stim == 2'h0);
      hold     <= (evs[i].stim != 2'h0);
      @(posedge hclk);
      glitch <= 1'b0;
      if (evs[i].stim == 2'h2) begin
        repeat (3) @(posedge hclk);
        hold <= 1'b0;
        repeat (2) @(posedge hclk);
        hold <= 1'b1;
      end
      watch(80);
      check("reset pulses", {28'h000_0000, n_rst}, {28'h000_0000, evs[i].n_rst});
      check("interrupt pulses", {28'h000_0000, n_int}, {28'h000_0000, evs[i].n_int});
      @(posedge hclk);
      hold <= 1'b0;
      repeat (10) @(posedge hclk);
    end
    // Status: noise flag left by the glitch row, then reporting switched off
    bus(1'b0, 12'h060, 32'h0000_0000, rd);
    check("status", rd, 32'h0000_0005);
    bus(1'b1, 12'h060, 32'h0000_0004, rd);
    bus(1'b1, 12'h030, 32'h0000_0007, rd);
    bus(1'b0, 12'h060, 32'h0000_0000, rd);
    check("status cleared", rd, 32'h0000_0000);
    hold <= 1'b1;
    watch(40);
    check("events while disabled", {24'h00_0000, n_rst, n_int}, 32'h0000_0000);
    @(posedge hclk);
    hold <= 1'b0;
    repeat (4) @(posedge hclk);
    // Reset in mid-wait: nothing late, control back to its reset value
    bus(1'b1, 12'h030, 32'h0000_000F, rd);
    hold <= 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    watch(80);
    check("events after reset", {24'h00_0000, n_rst, n_int}, 32'h0000_0000);
    @(posedge hclk);
    bus(1'b0, 12'h030, 32'h0000_0000, rd);
    check("control after reset", rd & 32'h0000_FFFF, 32'h0000_7FFD);
    hold <= 1'b0;
    test_done();
  end
endmodule : tb
